// ---- logic/tcs_pkg.sv ----
// Package of constants and types for the thermometer command sequencer
package tcs_pkg;
    localparam logic [3:0] TCS_ADDR_CODE = 4'h9;
    localparam logic [7:0] TCS_CMD_START_CONV = 8'h51;
    localparam logic [7:0] TCS_CMD_STOP_CONV = 8'h22;
    localparam logic [7:0] TCS_CMD_READ_TEMP = 8'haa;
    localparam logic [7:0] TCS_CMD_ACC_HIGH = 8'ha1;
    localparam logic [7:0] TCS_CMD_ACC_LOW = 8'ha2;
    localparam logic [7:0] TCS_CMD_ACC_CFG = 8'hac;
    localparam logic [7:0] TCS_CFG_RESET = 8'h00;
    localparam logic [15:0] TCS_THRESH_RESET = 16'h0000;
    localparam logic [7:0] TCS_CFG_FLAG_MASK = 8'h9f;
    localparam int TCS_CFG_RES_LSB = 2;
    localparam int TCS_CFG_ONESHOT_BIT = 0;
    localparam int TCS_CFG_POL_BIT = 1;

    typedef struct packed {
        logic [7:0] whole;
        logic [7:0] frac;
    } tcs_temp_type;

    typedef struct packed {
        logic [1:0] resolution;
        logic one_shot;
        logic polarity_high;
    } tcs_mode_type;

    typedef enum logic [2:0] {
        TCS_IDLE, TCS_ADDR, TCS_CMD, TCS_WDATA, TCS_RDATA, TCS_WAIT
    } tcs_state_type;
endpackage

// ---- logic/tcs_sequencer.sv ----
// I2C slave command sequencer of a temperature sensor
module tcs_sequencer
    import tcs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0,
    input wire tcs_temp_type temperature,
    input wire logic flag_high_set,
    input wire logic flag_low_set,
    output logic flag_high,
    output logic flag_low,
    output logic [7:0] config_value,
    output tcs_mode_type mode,
    output tcs_temp_type high_threshold,
    output tcs_temp_type low_threshold,
    output logic conv_start,
    output logic conv_stop
);
    logic [1:0] scl_sync_r, sda_sync_r;
    logic scl_d_r, sda_d_r;
    tcs_state_type state_r;
    logic [7:0] shift_r, cmd_r, tx_r;
    logic [3:0] bit_r;
    logic ack_phase_r, byte_idx_r, drive_r, drive_val_r;
    logic [7:0] cfg_r;
    tcs_temp_type high_r, low_r;
    logic flag_high_r, flag_low_r, start_r, stop_r;
    logic [2:0] sel_meta_r, sel_pins_r;

    // Sampled lines; first stage is read only by the second
    wire scl_s = scl_sync_r[1];
    wire sda_s = sda_sync_r[1];
    wire scl_rise = scl_s && !scl_d_r;
    wire scl_fall = !scl_s && scl_d_r;
    wire bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
    wire bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;
    wire [7:0] rx_byte = {shift_r[6:0], sda_s};
    wire addr_hit = rx_byte[7:4] == TCS_ADDR_CODE &&
        rx_byte[3:1] == sel_pins_r;
    // Only the first data byte reaches the config register
    wire cfg_write = state_r == TCS_WDATA && ack_phase_r == 1'b0 &&
        scl_rise && bit_r == 4'd7 && cmd_r == TCS_CMD_ACC_CFG &&
        !byte_idx_r;

    function automatic logic [7:0] read_byte(input logic [7:0] cmd,
                                            input logic idx);
        tcs_temp_type v;
        v = TCS_THRESH_RESET;
        unique case (cmd)
            TCS_CMD_READ_TEMP: v = temperature;
            TCS_CMD_ACC_HIGH: v = high_r;
            TCS_CMD_ACC_LOW: v = low_r;
            TCS_CMD_ACC_CFG: v = {cfg_r, cfg_r};
            default: v = TCS_THRESH_RESET;
        endcase
        // Most significant byte first
        read_byte = idx ? v.frac : v.whole;
    endfunction

    wire [7:0] rd_first = read_byte(cmd_r, 1'b0);
    wire [7:0] rd_second = read_byte(cmd_r, 1'b1);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            scl_sync_r <= 2'b11;
            sda_sync_r <= 2'b11;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            sel_meta_r <= 3'b000;
            sel_pins_r <= 3'b000;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            // Straps are pins: two stages before the address compare
            sel_meta_r <= {addr_select_bit2, addr_select_bit1,
                addr_select_bit0};
            sel_pins_r <= sel_meta_r;
        end
    end

    // Byte-level sequencing; bits sampled on SCL rise, driven after fall
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= TCS_IDLE;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            tx_r <= 8'h00;
            bit_r <= 4'd0;
            ack_phase_r <= 1'b0;
            byte_idx_r <= 1'b0;
            drive_r <= 1'b0;
            drive_val_r <= 1'b1;
            high_r <= TCS_THRESH_RESET;
            low_r <= TCS_THRESH_RESET;
            start_r <= 1'b0;
            stop_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            stop_r <= 1'b0;
            if (bus_start) begin
                // Repeated START keeps the last command for a following read
                state_r <= TCS_ADDR;
                bit_r <= 4'd0;
                ack_phase_r <= 1'b0;
                drive_r <= 1'b0;
            end else if (bus_stop) begin
                state_r <= TCS_IDLE;
                drive_r <= 1'b0;
            end else if (state_r != TCS_IDLE && state_r != TCS_WAIT) begin
                if (!ack_phase_r && scl_rise) begin
                    shift_r <= rx_byte;
                    bit_r <= bit_r + 4'd1;
                    if (bit_r == 4'd7) begin
                        ack_phase_r <= 1'b1;
                    end
                    if (state_r == TCS_RDATA) begin
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
                if (!ack_phase_r && scl_rise && bit_r == 4'd7) begin
                    unique case (state_r)
                        TCS_ADDR: if (!addr_hit) state_r <= TCS_WAIT;
                        TCS_CMD: begin
                            cmd_r <= rx_byte;
                            byte_idx_r <= 1'b0;
                            start_r <= rx_byte == TCS_CMD_START_CONV;
                            stop_r <= rx_byte == TCS_CMD_STOP_CONV;
                        end
                        TCS_WDATA: begin
                            // Bytes after the second overwrite the frac byte of the threshold again
                            if (cmd_r == TCS_CMD_ACC_HIGH) begin
                                if (!byte_idx_r) high_r.whole <= rx_byte;
                                else high_r.frac <= rx_byte;
                            end
                            if (cmd_r == TCS_CMD_ACC_LOW) begin
                                if (!byte_idx_r) low_r.whole <= rx_byte;
                                else low_r.frac <= rx_byte;
                            end
                        end
                        default: ;
                    endcase
                end
                if (ack_phase_r && scl_fall && bit_r == 4'd8) begin
                    // Ninth clock low: drive the acknowledge slot, except in TCS_RDATA where it is released
                    bit_r <= 4'd9;
                    drive_r <= state_r != TCS_RDATA;
                    drive_val_r <= 1'b0;
                end else if (!ack_phase_r && scl_fall && state_r ==
                        TCS_RDATA) begin
                    drive_r <= 1'b1;
                    drive_val_r <= tx_r[7];
                end
                if (ack_phase_r && scl_rise && bit_r == 4'd9) begin
                    bit_r <= 4'd10;
                    if (state_r == TCS_RDATA && sda_s) begin
                        state_r <= TCS_WAIT;
                    end
                end
                if (ack_phase_r && scl_fall && bit_r == 4'd10) begin
                    ack_phase_r <= 1'b0;
                    bit_r <= 4'd0;
                    drive_r <= 1'b0;
                    unique case (state_r)
                        TCS_ADDR: begin
                            if (shift_r[0]) begin
                                state_r <= TCS_RDATA;
                                byte_idx_r <= 1'b0;
                                tx_r <= rd_first;
                                drive_r <= 1'b1;
                                drive_val_r <= rd_first[7];
                            end else begin
                                state_r <= TCS_CMD;
                            end
                        end
                        TCS_CMD: state_r <= TCS_WDATA;
                        TCS_WDATA: byte_idx_r <= 1'b1;
                        TCS_RDATA: begin
                            byte_idx_r <= 1'b1;
                            tx_r <= rd_second;
                            drive_r <= 1'b1;
                            drive_val_r <= rd_second[7];
                        end
                        default: drive_r <= 1'b0;
                    endcase
                end
            end
        end
    end

    // Set from the sensor wins over the clear of a config write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_r <= TCS_CFG_RESET;
            flag_high_r <= 1'b0;
            flag_low_r <= 1'b0;
        end else begin
            if (cfg_write) begin
                cfg_r <= rx_byte & TCS_CFG_FLAG_MASK;
            end
            flag_high_r <= flag_high_set || (flag_high_r && !cfg_write);
            flag_low_r <= flag_low_set || (flag_low_r && !cfg_write);
        end
    end

    // 08h decodes to resolution 2 (11-bit), continuous, active-low
    assign mode.resolution = cfg_r[TCS_CFG_RES_LSB +: 2];
    assign mode.one_shot = cfg_r[TCS_CFG_ONESHOT_BIT];
    assign mode.polarity_high = cfg_r[TCS_CFG_POL_BIT];
    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = drive_r && !drive_val_r;
    assign flag_high = flag_high_r;
    assign flag_low = flag_low_r;
    assign config_value = cfg_r;
    assign high_threshold = high_r;
    assign low_threshold = low_r;
    assign conv_start = start_r;
    assign conv_stop = stop_r;

    AST_NACK_ADDR: assert property (@(posedge clk) disable iff (!resetn)
        state_r == TCS_ADDR && !ack_phase_r && scl_rise && bit_r == 4'd7 &&
        !addr_hit && !bus_start && !bus_stop |=> state_r == TCS_WAIT)
        else $error("address mismatch not ignored");
    AST_WAIT_QUIET: assert property (@(posedge clk) disable iff (!resetn)
        state_r == TCS_WAIT |-> !sda_oe)
        else $error("data line driven while waiting");
    AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!resetn)
        bus_stop |=> state_r == TCS_IDLE && !sda_oe)
        else $error("stop not honoured");
    AST_RESTART: assert property (@(posedge clk) disable iff (!resetn)
        bus_start |=> state_r == TCS_ADDR && bit_r == 4'd0)
        else $error("repeated start not honoured");
    AST_CFG_CLR: assert property (@(posedge clk) disable iff (!resetn)
        cfg_write && !flag_high_set && !flag_low_set |=>
        !flag_high && !flag_low)
        else $error("flags not cleared by config write");
    AST_START_CMD: assert property (@(posedge clk) disable iff (!resetn)
        conv_start |-> $past(state_r) == TCS_CMD &&
        cmd_r == TCS_CMD_START_CONV)
        else $error("start pulse without command");
    AST_ACK_DRV: assert property (@(posedge clk) disable iff (!resetn)
        ack_phase_r && bit_r == 4'd9 && state_r != TCS_RDATA &&
        state_r != TCS_WAIT && state_r != TCS_IDLE |-> sda_oe)
        else $error("acknowledge not driven");
    AST_HIGH_MSB: assert property (@(posedge clk) disable iff (!resetn)
        state_r == TCS_WDATA && cmd_r == TCS_CMD_ACC_HIGH && !byte_idx_r &&
        !ack_phase_r && scl_rise && bit_r == 4'd7 && !bus_start &&
        !bus_stop |=> high_threshold.whole == $past(rx_byte))
        else $error("high threshold msb not stored");
    AST_MODE: assert property (@(posedge clk) disable iff (!resetn)
        config_value == 8'h08 |-> mode.resolution == 2'd2 &&
        !mode.one_shot && !mode.polarity_high)
        else $error("config decode wrong");
endmodule // tcs_sequencer

// ---- testbench/tcs_i2c_master.sv ----
// Bus master model that clocks SCL and pulls SDA low
module tcs_i2c_master (
    input wire logic clk,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // SDA moves well after the SCL fall so that a false START or STOP
    // never reaches the slave's synchronisers
    task automatic bit_io(input logic b, output logic r);
        wt(4);
        sda_oe <= ~b;
        wt(8);
        scl <= 1'b1;
        wt(12);
        r = sda_bus;
        scl <= 1'b0;
    endtask

    // Also serves as the repeated START; SCL is low between bytes
    task automatic start;
        wt(4);
        sda_oe <= 1'b0;
        wt(8);
        scl <= 1'b1;
        wt(12);
        sda_oe <= 1'b1;
        wt(12);
        scl <= 1'b0;
    endtask

    task automatic stop;
        wt(4);
        sda_oe <= 1'b1;
        wt(8);
        scl <= 1'b1;
        wt(12);
        sda_oe <= 1'b0;
        wt(12);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, r);
    endtask
endmodule // tcs_i2c_master

// ---- testbench/thermo_i2c_command_sequencer_tb_top.sv ----
// Self-checking testbench of the thermometer command sequencer
module thermo_i2c_command_sequencer_tb_top import tcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] SEL = 3'h5;
    localparam logic [7:0] AW = {TCS_ADDR_CODE, SEL, 1'b0};
    localparam logic [7:0] AR = {TCS_ADDR_CODE, SEL, 1'b1};
    logic clk = 1'b0;
    logic resetn, scl, mst_oe, sda_out, sda_oe, fhs, fls, flag_high, flag_low;
    logic cst, csp;
    logic [2:0] sel;
    logic [7:0] cfg;
    tcs_temp_type temp, hth, lth;
    tcs_mode_type mode;
    int error_cnt = 0, comparisons = 0, cycles = 0, n_start = 0, n_stop = 0;
    // Open-drain wire with a pull-up
    wire sda_bus = ~(sda_oe | mst_oe);

    always #2 clk = ~clk;

    tcs_i2c_master u_mst (.clk(clk), .sda_bus(sda_bus), .scl(scl),
        .sda_oe(mst_oe));

    tcs_sequencer u_dut (.clk(clk), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_bit2(sel[2]), .addr_select_bit1(sel[1]),
        .addr_select_bit0(sel[0]), .temperature(temp),
        .flag_high_set(fhs), .flag_low_set(fls), .flag_high(flag_high),
        .flag_low(flag_low), .config_value(cfg), .mode(mode),
        .high_threshold(hth), .low_threshold(lth), .conv_start(cst),
        .conv_stop(csp));

    task automatic stop_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] d, input logic ack);
        logic a;
        u_mst.wr_byte(d, a);
        chk({15'h0000, a}, {15'h0000, ack}, "ack");
    endtask

    task automatic rd(input logic nack, input logic [7:0] exp);
        logic [7:0] d;
        u_mst.rd_byte(nack, d);
        chk({8'h00, d}, {8'h00, exp}, "read byte");
    endtask

    // Counting high cycles also catches a pulse that lasts too long
    always @(posedge clk) begin
        n_start <= n_start + int'(cst === 1'b1);
        n_stop <= n_stop + int'(csp === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            stop_test();
        end
    end

    initial begin
        resetn = 1'b0;
        fhs = 1'b0;
        fls = 1'b0;
        sel = SEL;
        temp = 16'h1990;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        u_mst.wt(4);
        chk({sda_out, sda_oe, flag_high, flag_low, mode, cfg}, 16'h0000,
            "rst");
        chk(hth | lth, 16'h0000, "thresholds after reset");
        u_mst.start();
        wr(8'h98, 1'b0);
        u_mst.stop();
        u_mst.start();
        wr(8'h1a, 1'b0);
        u_mst.stop();
        fhs <= 1'b1;
        fls <= 1'b1;
        u_mst.wt(1);
        fhs <= 1'b0;
        fls <= 1'b0;
        u_mst.wt(2);
        chk({14'h0, flag_high, flag_low}, 16'h0003, "flags set");
        u_mst.start();
        wr(AW, 1'b1);
        wr(TCS_CMD_ACC_CFG, 1'b1);
        wr(8'h08, 1'b1);
        chk({8'h00, cfg}, 16'h0008, "config");
        chk({12'h000, mode}, 16'h0008, "mode");
        chk({14'h0, flag_high, flag_low}, 16'h0000, "flags clr");
        u_mst.start();
        wr(AW, 1'b1);
        wr(TCS_CMD_ACC_HIGH, 1'b1);
        wr(8'h32, 1'b1);
        wr(8'h00, 1'b1);
        u_mst.start();
        wr(AW, 1'b1);
        wr(TCS_CMD_ACC_LOW, 1'b1);
        wr(8'h2d, 1'b1);
        wr(8'h00, 1'b1);
        chk(hth, 16'h3200, "high threshold");
        chk(lth, 16'h2d00, "low threshold");
        u_mst.start();
        wr(AW, 1'b1);
        wr(TCS_CMD_START_CONV, 1'b1);
        u_mst.start();
        wr(AW, 1'b1);
        wr(TCS_CMD_STOP_CONV, 1'b1);
        u_mst.stop();
        chk(16'(n_start), 16'h0001, "start pulses");
        chk(16'(n_stop), 16'h0001, "stop pulses");
        u_mst.start();
        wr(AW, 1'b1);
        wr(TCS_CMD_READ_TEMP, 1'b1);
        u_mst.start();
        wr(AR, 1'b1);
        rd(1'b0, 8'h19);
        rd(1'b1, 8'h90);
        u_mst.wt(14);
        chk({15'h0000, sda_oe}, 16'h0000, "released");
        rd(1'b1, 8'hff);
        u_mst.stop();
        stop_test();
    end
endmodule // thermo_i2c_command_sequencer_tb_top
